//--- core/vpgid_pkg.sv
package vpgid_pkg;

  // Field positions of the thread identity word
  localparam int CLUSTER_LSB = 16;
  localparam int CORE_LSB    = 8;
  localparam int SLOT_LSB    = 0;

  // Numbering method shared by every virtual processor
  localparam bit NUMBERING_CONTIG     = 1'b1;
  localparam int TOTAL_VP_IN_CLUSTER  = 11;
  localparam int MAX_THREADS_PER_CORE = 4;
  localparam int SLOT_BITS = NUMBERING_CONTIG ? $clog2(TOTAL_VP_IN_CLUSTER)
                                              : $clog2(MAX_THREADS_PER_CORE);
  localparam int MAX_SLOT_SHIFT = $clog2(MAX_THREADS_PER_CORE);

  // Implemented bits of each identifier field
  localparam bit       CLUSTERING_EN     = 1'b1;
  localparam int       CLUSTER_IMPL_BITS = 2;
  localparam int       CORE_IMPL_BITS    = 2;
  localparam logic [3:0] CLUSTER_MASK =
    CLUSTERING_EN ? 4'((1 << CLUSTER_IMPL_BITS) - 1) : 4'h0;
  localparam logic [3:0] CORE_MASK = 4'((1 << CORE_IMPL_BITS) - 1);
  localparam logic [7:0] SLOT_MASK = 8'((1 << SLOT_BITS) - 1);

  // Hardware preset identifiers, taken at reset
  localparam logic [3:0] CLUSTER_PRESET = 4'h0;
  localparam logic [3:0] CORE_PRESET    = 4'h0;
  localparam logic [7:0] SLOT_PRESET    = 8'h00;

  // Virtual processor multithreading is present in this core
  localparam bit VP_MT_PRESENT = 1'b1;

  // Configuration register offsets (byte addresses)
  localparam logic [7:0] CFG_CTRL_OFS  = 8'h00;
  localparam logic [7:0] CFG_IDSET_OFS = 8'h04;
  localparam logic [7:0] CFG_APPLY_OFS = 8'h08;
  localparam logic [7:0] CFG_IDENT_OFS = 8'h0c;
  localparam logic [7:0] CFG_VCPU_OFS  = 8'h10;

  // Reset values of the configuration registers
  localparam logic        CTRL_EXT_EN_RST = 1'b0;
  localparam logic [31:0] IDSET_RST       = 32'h0000_0000;

endpackage

//--- core/vpgid_link_if.sv
`timescale 1ns/1ps
interface vpgid_link_if;
  logic [3:0]  cluster_index;     // Externally programmed cluster
  logic [3:0]  core_index;        // Externally programmed core
  logic [7:0]  thread_slot_index; // Externally programmed slot
  logic        ext_en;            // External programming enabled
  logic        load;              // One-cycle load strobe
  logic [31:0] ident;             // Identity word reported back

  modport dev (
    input  cluster_index,
    input  core_index,
    input  thread_slot_index,
    input  ext_en,
    input  load,
    output ident
  );

  modport cfg (
    output cluster_index,
    output core_index,
    output thread_slot_index,
    output ext_en,
    output load,
    input  ident
  );
endinterface

//--- core/vpgid_device.sv
// Contract
// [R1] Cluster index at bits 19:16, read-only
// [R2] No clustering: cluster field reads reserved zero
// [R3] Core index at bits 11:8, read-only
// [R4] Thread slot index at bits 7:0, read-only
// [R5] Unimplemented field bits unwritable, read zero
// [R6] Fields from preset or external register
// [R7] External logic may reassign identifiers
// [R8] Contiguous: slot bits ceil log2 cluster total
// [R9] Non-contiguous: slot bits log2 per-core max
// [R10] Contiguous number is core plus slot
// [R11] Non-contiguous: core times max, OR slot
// [R12] One numbering method across the system
// [R13] Present whenever VP multithreading exists
// [R14] Bits 31:20 and 15:12 read zero
// [R15] Read returns whole word; writes change nothing
//
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module vpgid_device
  import vpgid_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Link to configuration logic
  vpgid_link_if.dev        link,
  // Coprocessor register port
  input  wire logic        cop_rd_i,
  input  wire logic        cop_wr_i,
  input  wire logic [31:0] cop_wdata_i,
  output logic      [31:0] cop_rdata_o,
  output logic             cop_ack_o,
  output logic             vp_multithread_flag_o
);
  import vpgid_pkg::*;

  // What this register offers software:
  // - one read-only word naming the current hardware thread
  // - a cluster index, a core index within the cluster and a
  //   thread slot index within the core
  // - from core and slot, software derives a virtual cpu number,
  //   either by adding them (contiguous numbering) or by shifting
  //   the core by log2 of the per-core thread maximum and merging the slot
  //   (non-contiguous numbering)
  // - the cluster index and that number together name the thread
  //   uniquely in the whole system
  // The numbering method is a system-wide choice; mixing methods
  // between cores gives colliding numbers, so it lives in the
  // shared package and not in this module.

  // Limits a user must know:
  // - the fields come from the preset after reset, and later only
  //   from an enabled external load; instructions cannot change them
  // - a read in the cycle of a load still returns the old word
  // - loads may follow each other back to back
  // - ce_i low freezes every flop, including the acknowledge, so a
  //   request made while frozen is answered only once ce_i returns
  // - with clustering absent the cluster mask is zero and the field
  //   reads as reserved zero

  // Packed identifier layout inside this module:
  // cluster in [15:12], core in [11:8], slot in [7:0]
  localparam int          ID_BITS   = 16;
  localparam int          CLUS_BASE = 12;
  localparam int          CORE_BASE = 8;
  localparam logic [15:0] ID_IMPL   = {CLUSTER_MASK, CORE_MASK, SLOT_MASK};
  localparam logic [15:0] ID_PRESET = {CLUSTER_PRESET, CORE_PRESET, SLOT_PRESET};

  // Storage, decode and answer signals
  logic       [15:0] ext_id;
  wire  logic [15:0] id_w;
  wire  logic [31:0] ident_word;
  logic       [3:0]  cluster_w;
  logic       [3:0]  core_w;
  logic       [7:0]  slot_w;
  logic              ext_load;
  logic              cop_req;
  logic              cop_rd_take;
  logic       [31:0] wdata_unused;

  // Staged identifiers as offered by the configuration end;
  // unimplemented positions are dropped here already
  assign cluster_w = link.cluster_index & CLUSTER_MASK;     // R1 R2 R5
  assign core_w    = link.core_index & CORE_MASK;           // R3 R5
  assign slot_w    = link.thread_slot_index & SLOT_MASK;    // R4 R5 R8 R9
  assign ext_id    = {cluster_w, core_w, slot_w};

  // External load only when programming is enabled; a strobe that
  // arrives with the enable low is ignored, so a stray strobe after
  // software has locked the identity leaves it untouched
  assign ext_load = link.load & link.ext_en; // R6 R7

  // One storage bit per identifier position; unimplemented positions
  // get no flop at all, so no path can ever set them
  for (genvar b = 0; b < ID_BITS; b++) begin : g_id_bit
    if (ID_IMPL[b]) begin : g_impl
      logic bit_q;

      // Preset at reset, reloaded only by an enabled external load
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          bit_q <= ID_PRESET[b]; // R6
        end else if (ce_i && ext_load) begin
          bit_q <= ext_id[b]; // R6 R7
        end
      end

      assign id_w[b] = bit_q;
    end else begin : g_none
      // Position not implemented: reads as zero whatever is loaded
      assign id_w[b] = 1'b0; // R2 R5
    end
  end

  // Identity word, bit by bit: identifier positions take the stored
  // bit, the reserved ranges read as zero
  for (genvar w = 0; w < 32; w++) begin : g_word_bit
    if (w >= CLUSTER_LSB && w < CLUSTER_LSB + 4) begin : g_cluster
      // Cluster index field
      assign ident_word[w] = id_w[w - CLUSTER_LSB + CLUS_BASE]; // R1 R2
    end else if (w >= CORE_LSB && w < CORE_LSB + 4) begin : g_core
      // Core index field
      assign ident_word[w] = id_w[w - CORE_LSB + CORE_BASE]; // R3
    end else if (w >= SLOT_LSB && w < SLOT_LSB + 8) begin : g_slot
      // Thread slot field, width set by the numbering method
      assign ident_word[w] = id_w[w - SLOT_LSB]; // R4 R8 R9
    end else begin : g_reserved
      // Reserved ranges 31:20 and 15:12
      assign ident_word[w] = 1'b0; // R14
    end
  end

  // Write data never reaches any field; the identity is read-only
  // to instructions and changes only through the external path
  assign wdata_unused = cop_wdata_i & 32'h0000_0000; // R15

  // Coprocessor request decode
  assign cop_req     = ce_i & (cop_rd_i | cop_wr_i);
  assign cop_rd_take = ce_i & cop_rd_i;

  // Acknowledge: one pulse per request cycle, writes included,
  // which are accepted and then ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cop_ack_o <= 1'b0;
    end else if (ce_i) begin
      cop_ack_o <= cop_req; // R15
    end
  end

  // Read data: the whole word at once, held until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cop_rdata_o <= 32'h0000_0000;
    end else if (cop_rd_take) begin
      cop_rdata_o <= ident_word | wdata_unused; // R15
    end
  end

  // Identity reported back to the configuration end, one cycle
  // behind the stored fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.ident <= 32'h0000_0000;
    end else if (ce_i) begin
      link.ident <= ident_word;
    end
  end

  // Multithreading presence flag; constant once out of reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vp_multithread_flag_o <= 1'b0;
    end else if (ce_i) begin
      vp_multithread_flag_o <= VP_MT_PRESENT; // R13
    end
  end

endmodule // vpgid_device

//--- core/vpgid_config.sv
`timescale 1ns/1ps
module vpgid_config
  import vpgid_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Link to the identity register
  vpgid_link_if.cfg        link,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);
  import vpgid_pkg::*;

  logic        ext_en_q;
  logic [31:0] idset_q;
  logic [31:0] wmask;
  logic        req;
  logic        wr_ctrl;
  logic        wr_idset;
  logic        wr_apply;
  logic [15:0] vcpu_num;
  logic [15:0] core_ext;
  logic [15:0] slot_ext;
  logic [31:0] rdata;

  // Request decode; one answer per request
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_ctrl  = req & wb_we_i & (wb_adr_i == CFG_CTRL_OFS);
  assign wr_idset = req & wb_we_i & (wb_adr_i == CFG_IDSET_OFS);
  assign wr_apply = req & wb_we_i & (wb_adr_i == CFG_APPLY_OFS);
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Virtual processor number from the reported identity
  assign core_ext = {12'h000, link.ident[CORE_LSB +: 4]};
  assign slot_ext = {8'h00, link.ident[SLOT_LSB +: 8]};
  assign vcpu_num = NUMBERING_CONTIG ? 16'(core_ext + slot_ext)             // R10 R12
                  : 16'((core_ext << MAX_SLOT_SHIFT) | slot_ext);        // R11 R12

  // Read multiplexer; unmapped offsets read zero
  assign rdata = (wb_adr_i == CFG_CTRL_OFS)  ? {31'h0, ext_en_q} :
                 (wb_adr_i == CFG_IDSET_OFS) ? idset_q :
                 (wb_adr_i == CFG_IDENT_OFS) ? link.ident :
                 (wb_adr_i == CFG_VCPU_OFS)  ? {16'h0000, vcpu_num} :
                 32'h0000_0000;

  // Control and staged identifier registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_en_q <= CTRL_EXT_EN_RST;
      idset_q  <= IDSET_RST;
    end else if (ce_i) begin
      if (wr_ctrl && wb_sel_i[0]) begin
        ext_en_q <= wb_dat_i[0];
      end
      if (wr_idset) begin
        idset_q <= (idset_q & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  // Bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Link drive: apply write produces one load strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.cluster_index     <= 4'h0;
      link.core_index        <= 4'h0;
      link.thread_slot_index <= 8'h00;
      link.ext_en            <= 1'b0;
      link.load              <= 1'b0;
    end else if (ce_i) begin
      link.cluster_index     <= idset_q[CLUSTER_LSB +: 4]; // R6
      link.core_index        <= idset_q[CORE_LSB +: 4];    // R6
      link.thread_slot_index <= idset_q[SLOT_LSB +: 8];    // R6
      link.ext_en            <= ext_en_q;
      link.load              <= wr_apply;                  // R7
    end
  end

endmodule // vpgid_config

//--- verification/vpgid_sva.sv
`timescale 1ns/1ps
module vpgid_sva
  import vpgid_pkg::*;
(
  // Clock, reset, enable
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Link signals
  input wire logic [3:0]  cluster_index,
  input wire logic [3:0]  core_index,
  input wire logic [7:0]  thread_slot_index,
  input wire logic        ext_en,
  input wire logic        load,
  input wire logic [31:0] ident
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Enabled load and the masked word it should produce
  wire logic        apply_w = load && ext_en && ce_i;
  wire logic [31:0] staged_w = {12'h000, cluster_index & CLUSTER_MASK, 4'h0,
                                core_index & CORE_MASK, thread_slot_index & SLOT_MASK};
  sequence apply_s;
    apply_w;
  endsequence
  hi_zero_a: assert property (ident[31:20] == 12'h000)
    else $error("ident upper bits set");
  mid_zero_a: assert property (ident[15:12] == 4'h0)
    else $error("ident middle bits set");
  clus_mask_a: assert property ((ident[19:16] & ~CLUSTER_MASK) == 4'h0)
    else $error("unimplemented cluster bit set");
  core_mask_a: assert property ((ident[11:8] & ~CORE_MASK) == 4'h0)
    else $error("unimplemented core bit set");
  slot_mask_a: assert property ((ident[7:0] & ~SLOT_MASK) == 8'h00)
    else $error("unimplemented slot bit set");
  load_word_a: assert property (apply_s |-> ##2 ident == $past(staged_w, 2))
    else $error("loaded word not reported");
  ident_hold_a: assert property ($changed(ident) |-> $past(apply_w, 2))
    else $error("ident changed without load");
  load_lat_a: assert property (apply_w && !$past(apply_w) |=> $stable(ident))
    else $error("ident changed too early");
endmodule // vpgid_sva

//--- verification/vpgid_tb_top.sv
`timescale 1ns/1ps
module vpgid_tb_top;
  import vpgid_pkg::*;
  // Bench signals
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        crd   = 1'b0;
  logic        cwr   = 1'b0;
  logic [31:0] crdat;
  logic        cack;
  logic        flag;
  logic [31:0] d;
  logic [31:0] ful;
  logic [31:0] vexp;
  int          n_fail  = 0;
  int          n_tests = 0;
  vpgid_link_if link ();
  vpgid_device u_vpgid_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link),
    .cop_rd_i(crd), .cop_wr_i(cwr), .cop_wdata_i(32'hffff_ffff), .cop_rdata_o(crdat),
    .cop_ack_o(cack), .vp_multithread_flag_o(flag));
  vpgid_config u_vpgid_config (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(link),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  vpgid_sva u_vpgid_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cluster_index(link.cluster_index), .core_index(link.core_index),
    .thread_slot_index(link.thread_slot_index), .ext_en(link.ext_en),
    .load(link.load), .ident(link.ident));
  // Clock
  always #25 clk_i = ~clk_i;
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Wishbone classic single cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= v;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin n_fail++; report_and_stop; end
    d = rdat;
    cyc <= 1'b0; we <= 1'b0;
  endtask
  // Coprocessor read or write
  task cop(input logic w);
    int i;
    @(posedge clk_i);
    crd <= !w; cwr <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (cack === 1'b1) break;
    end
    if (i == 20) begin n_fail++; report_and_stop; end
    d = crdat;
    crd <= 1'b0; cwr <= 1'b0;
  endtask
  // Apply staged ids and let the word settle
  task apply;
    wb(1'b1, CFG_APPLY_OFS, 32'h0);
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    ful = {12'h000, CLUSTER_MASK, 4'h0, CORE_MASK, SLOT_MASK};
    vexp = NUMBERING_CONTIG ? 32'(CORE_MASK) + 32'(SLOT_MASK)
                            : (32'(CORE_MASK) << MAX_SLOT_SHIFT) | 32'(SLOT_MASK);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CFG_CTRL_OFS, 32'h0); chk("ctrl", {31'h0, CTRL_EXT_EN_RST}, d);
    wb(1'b0, CFG_IDSET_OFS, 32'h0); chk("idset", IDSET_RST, d);
    cop(1'b0); chk("preset", 32'h0, d);
    chk("flag", 32'h1, {31'h0, flag});
    wb(1'b1, CFG_CTRL_OFS, 32'h1);
    wb(1'b1, CFG_IDSET_OFS, 32'hffff_ffff);
    apply();
    cop(1'b0); chk("full", ful, d);
    wb(1'b0, CFG_VCPU_OFS, 32'h0); chk("vcpu", vexp, d);
    cop(1'b1); cop(1'b0); chk("after write", ful, d);
    wb(1'b1, 8'h20, 32'h1234_5678); wb(1'b0, 8'h20, 32'h0); chk("unmapped", 32'h0, d);
    wb(1'b1, CFG_CTRL_OFS, 32'h0);
    wb(1'b1, CFG_IDSET_OFS, 32'h0001_0102);
    apply();
    wb(1'b0, CFG_IDENT_OFS, 32'h0); chk("disabled", ful, d);
    wb(1'b1, CFG_CTRL_OFS, 32'h1);
    apply();
    cop(1'b0); chk("reassign", 32'h0001_0102, d);
    wb(1'b0, CFG_VCPU_OFS, 32'h0); chk("vcpu", 32'h3, d);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    cop(1'b0); chk("reset", 32'h0, d);
    report_and_stop;
  end
endmodule // vpgid_tb_top
